//--- core/cpu_exec_defines.svh
// Constants for the instruction execution subset: encodings, field positions, reset values
`ifndef CPU_EXEC_DEFINES_SVH
`define CPU_EXEC_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define OPCODE_W 14
`define DATA_W 8
`define PC_W 15
`define FADDR_W 7
`define BANK_W 2
`define FILE_ADDR_W 9
`define PCH_W 7
`define STACK_PTR_W 4

// ----------------------------------------------------------------
// Opcode field positions
// ----------------------------------------------------------------
`define DEST_BIT 7
`define FADDR_MSB 6
`define FADDR_LSB 0

// ----------------------------------------------------------------
// Opcode encodings: exact matches and masked matches
// ----------------------------------------------------------------
`define OP_WDT_CLEAR 14'h0064
`define OP_ACCUM_CALL 14'h000A
`define OP_MASK_FD 14'h3F00
`define OP_MASK_F 14'h3F80
`define OP_CLEAR_ACCUM 14'h0100
`define OP_CLEAR_FILE 14'h0180
`define OP_COMPLEMENT 14'h0900
`define OP_DECREMENT 14'h0300
`define OP_DEC_SKIP 14'h0B00

// ----------------------------------------------------------------
// Values and reset values
// ----------------------------------------------------------------
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define PC_ONE 15'h0001
`define PC_RESET 15'h0000
`define ACCUM_RESET 8'h00
`define SP_ONE 4'h1
`define SP_RESET 4'h0

`endif

//--- core/cpu_exec_pkg.sv
// Types shared by the execution subset modules
package cpu_exec_pkg;

  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_EXEC  = 3'b010,
    ST_FLUSH = 3'b100
  } exec_state_t;

  typedef logic [13:0] opcode_t;
  typedef logic [7:0] byte_t;
  typedef logic [14:0] pc_t;

endpackage : cpu_exec_pkg

//--- core/file_mem_if.sv
// Port between the execution sequencer and the file register memory
`timescale 1ns/1ns
`default_nettype none
`include "cpu_exec_defines.svh"

interface file_mem_if;
  logic [`FILE_ADDR_W-1:0] addr;
  logic wr_en;
  logic [`DATA_W-1:0] wdata;
  logic [`DATA_W-1:0] rdata;

  modport ctrl (output addr, output wr_en, output wdata, input rdata);
  modport mem (input addr, input wr_en, input wdata, output rdata);
endinterface : file_mem_if

`default_nettype wire

//--- core/file_mem.sv
// File register memory, single port, registered read data
`timescale 1ns/1ns
`default_nettype none
`include "cpu_exec_defines.svh"

module file_mem (
  input wire logic i_clock,
  file_mem_if.mem bus
);
  import cpu_exec_pkg::*;

  localparam int DEPTH = 1 << `FILE_ADDR_W;

  byte_t store [DEPTH];

  // ----------------------------------------------------------------
  // Write, then read old contents into the output register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (bus.wr_en) begin
      store[bus.addr] <= bus.wdata;
    end
    bus.rdata <= store[bus.addr];
  end

endmodule : file_mem

`default_nettype wire

//--- core/cpu_instr_exec_subset.sv
// Executes watchdog clear, accumulator call, complement, clears and decrements
// What this block does
// - Watchdog clear zeroes counter and prescaler, sets both active-low status flags.
// - Accumulator call pushes current address plus one onto the return stack.
// - Accumulator call loads low address from accumulator, high from latch bits 6..0.
// - Accumulator call takes two instruction cycles, flags untouched.
// - Complement inverts file register, routes by destination bit, updates zero flag.
// - File clear writes zero to register and sets zero flag.
// - Accumulator clear writes zero to accumulator and sets zero flag.
// - Decrement subtracts one, routes by destination bit, updates zero flag.
// - Decrement-skip subtracts one, routes by destination bit, flags untouched.
// - Zero result of decrement-skip squashes the next instruction into a no-op.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_exec_defines.svh"

module cpu_instr_exec_subset #(
  parameter int STACK_DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_instr_valid,
  input wire cpu_exec_pkg::opcode_t i_opcode,
  input wire logic [`BANK_W-1:0] i_bank,
  input wire logic [`PCH_W-1:0] i_pc_high_latch,
  input wire logic i_timeout_event,
  input wire logic i_sleep_entry,
  output logic o_ready,
  output cpu_exec_pkg::pc_t o_pc,
  output cpu_exec_pkg::byte_t o_accum,
  output logic o_zero_flag,
  output logic o_timeout_flag_n,
  output logic o_powerdown_flag_n,
  output logic o_wdt_clear,
  output logic o_prescaler_clear,
  output cpu_exec_pkg::pc_t o_stack_top,
  output logic [`STACK_PTR_W-1:0] o_stack_ptr,
  output logic o_squashed,
  output logic o_unhandled
);
  import cpu_exec_pkg::*;

  exec_state_t state_reg, state_next;
  opcode_t op_reg;
  logic live_reg;
  logic skip_pending_reg;
  logic [`FILE_ADDR_W-1:0] addr_reg;
  pc_t pc_reg;
  byte_t accum_reg;
  logic zero_reg;
  logic timeout_n_reg, powerdown_n_reg;
  logic wdt_clear_reg, squashed_reg, unhandled_reg;
  logic [`STACK_PTR_W-1:0] sp_reg;
  pc_t stack_reg [STACK_DEPTH];

  file_mem_if mem_bus ();

  file_mem u_file_mem (
    .i_clock(i_clock),
    .bus(mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // Decode of the held opcode
  // ----------------------------------------------------------------
  wire logic accept = (state_reg == ST_READY) && i_instr_valid;
  wire logic in_exec = (state_reg == ST_EXEC) && live_reg;
  wire logic dest_file = op_reg[`DEST_BIT];
  wire logic is_wdt = in_exec && (op_reg == `OP_WDT_CLEAR);
  wire logic is_call = in_exec && (op_reg == `OP_ACCUM_CALL);
  wire logic is_clear_accum_op = in_exec && ((op_reg & `OP_MASK_F) == `OP_CLEAR_ACCUM);
  wire logic is_clear_file_op = in_exec && ((op_reg & `OP_MASK_F) == `OP_CLEAR_FILE);
  wire logic is_complement_file_op = in_exec && ((op_reg & `OP_MASK_FD) == `OP_COMPLEMENT);
  wire logic is_decrement_file_op = in_exec && ((op_reg & `OP_MASK_FD) == `OP_DECREMENT);
  wire logic is_dsz = in_exec && ((op_reg & `OP_MASK_FD) == `OP_DEC_SKIP);
  wire logic is_known = is_wdt | is_call | is_clear_accum_op | is_clear_file_op | is_complement_file_op | is_decrement_file_op | is_dsz;

  // ----------------------------------------------------------------
  // Result path from the file register read
  // ----------------------------------------------------------------
  wire byte_t file_val = mem_bus.rdata;
  wire byte_t dec_val = file_val - `BYTE_ONE;
  wire byte_t com_val = ~file_val;
  wire byte_t result = is_complement_file_op ? com_val : ((is_decrement_file_op | is_dsz) ? dec_val : `BYTE_ZERO);
  wire logic result_zero = (result == `BYTE_ZERO);
  wire logic fd_op = is_complement_file_op | is_decrement_file_op | is_dsz;
  wire logic write_file = (fd_op && dest_file) || is_clear_file_op;
  wire logic write_accum = (fd_op && !dest_file) || is_clear_accum_op;
  wire logic zero_update = is_complement_file_op | is_decrement_file_op | is_clear_file_op | is_clear_accum_op;
  wire logic zero_value = (is_clear_file_op | is_clear_accum_op) ? 1'b1 : result_zero;
  wire logic take_skip = is_dsz && result_zero;

  // ----------------------------------------------------------------
  // Memory port and program counter arithmetic
  // ----------------------------------------------------------------
  wire logic [`FILE_ADDR_W-1:0] fetch_addr = {i_bank, i_opcode[`FADDR_MSB:`FADDR_LSB]};
  assign mem_bus.addr = (state_reg == ST_READY) ? fetch_addr : addr_reg;
  assign mem_bus.wr_en = write_file;
  assign mem_bus.wdata = result;
  wire pc_t pc_inc = pc_reg + `PC_ONE;
  wire pc_t call_target = {i_pc_high_latch, accum_reg};
  wire logic [`STACK_PTR_W-1:0] sp_top = sp_reg - `SP_ONE;

  // ----------------------------------------------------------------
  // Sequencer: fetch, execute, extra cycle for the call
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_READY: begin
        if (accept) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = is_call ? ST_FLUSH : ST_READY;
      end
      ST_FLUSH: begin
        state_next = ST_READY;
      end
      default: begin
        state_next = ST_READY;
      end
    endcase
  end

  // Opcode capture; a pending skip makes the fetched word dead
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= ST_READY;
      op_reg <= '0;
      live_reg <= 1'b0;
      addr_reg <= '0;
      skip_pending_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        op_reg <= i_opcode;
        addr_reg <= fetch_addr;
        live_reg <= !skip_pending_reg;
        skip_pending_reg <= 1'b0;
      end else if (take_skip) begin
        skip_pending_reg <= 1'b1;
      end
    end
  end

  // Program counter, accumulator and zero flag
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pc_reg <= `PC_RESET;
      accum_reg <= `ACCUM_RESET;
      zero_reg <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      pc_reg <= is_call ? call_target : pc_inc;
      if (write_accum) begin
        accum_reg <= result;
      end
      if (zero_update) begin
        zero_reg <= zero_value;
      end
    end
  end

  // Watchdog flags; the clear instruction wins over a same-cycle event
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      timeout_n_reg <= 1'b1;
      powerdown_n_reg <= 1'b1;
      wdt_clear_reg <= 1'b0;
      squashed_reg <= 1'b0;
      unhandled_reg <= 1'b0;
    end else begin
      wdt_clear_reg <= is_wdt;
      squashed_reg <= (state_reg == ST_EXEC) && !live_reg;
      unhandled_reg <= in_exec && !is_known;
      if (is_wdt) begin
        timeout_n_reg <= 1'b1;
        powerdown_n_reg <= 1'b1;
      end else begin
        if (i_timeout_event) begin
          timeout_n_reg <= 1'b0;
        end
        if (i_sleep_entry) begin
          powerdown_n_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Return stack, circular on overflow
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sp_reg <= `SP_RESET;
    end else if (is_call) begin
      sp_reg <= sp_reg + `SP_ONE;
    end
  end

  for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_stack
    wire logic push_here = is_call && (int'(sp_reg) == g);
    always_ff @(posedge i_clock) begin
      if (i_srst) begin
        stack_reg[g] <= `PC_RESET;
      end else if (push_here) begin
        stack_reg[g] <= pc_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_ready = (state_reg == ST_READY);
  assign o_pc = pc_reg;
  assign o_accum = accum_reg;
  assign o_zero_flag = zero_reg;
  assign o_timeout_flag_n = timeout_n_reg;
  assign o_powerdown_flag_n = powerdown_n_reg;
  assign o_wdt_clear = wdt_clear_reg;
  assign o_prescaler_clear = wdt_clear_reg;
  assign o_stack_top = stack_reg[sp_top];
  assign o_stack_ptr = sp_reg;
  assign o_squashed = squashed_reg;
  assign o_unhandled = unhandled_reg;

endmodule : cpu_instr_exec_subset

`default_nettype wire

//--- tb/cpu_exec_properties.sv
// Port checker for the execution subset
`timescale 1ns/1ns
`default_nettype none
`include "cpu_exec_defines.svh"
module cpu_exec_properties (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_instr_valid,
  input wire cpu_exec_pkg::opcode_t i_opcode,
  input wire logic [`PCH_W-1:0] i_pc_high_latch,
  input wire logic o_ready,
  input wire cpu_exec_pkg::pc_t o_pc,
  input wire cpu_exec_pkg::byte_t o_accum,
  input wire logic o_zero_flag,
  input wire logic o_timeout_flag_n,
  input wire logic o_powerdown_flag_n,
  input wire logic o_wdt_clear,
  input wire logic o_prescaler_clear,
  input wire cpu_exec_pkg::pc_t o_stack_top,
  input wire logic [`STACK_PTR_W-1:0] o_stack_ptr,
  input wire logic o_squashed
);
  import cpu_exec_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // Accepted opcode decodes
  wire logic take = o_ready && i_instr_valid;
  wire logic is_call = take && i_opcode == `OP_ACCUM_CALL;
  wire logic is_wdt = take && i_opcode == `OP_WDT_CLEAR;
  wire logic is_clear_accum_op = take && (i_opcode & `OP_MASK_F) == `OP_CLEAR_ACCUM;
  wire logic is_clear_file_op = take && (i_opcode & `OP_MASK_F) == `OP_CLEAR_FILE;
  wire logic is_dsk = take && (i_opcode & `OP_MASK_FD) == `OP_DEC_SKIP;
  property p_wdt;
    is_wdt |-> ##2 o_squashed || (o_wdt_clear && o_prescaler_clear && o_timeout_flag_n && o_powerdown_flag_n);
  endproperty
  property p_call_pc;
    is_call |-> ##2 o_squashed || o_pc == {$past(i_pc_high_latch), $past(o_accum)};
  endproperty
  property p_push;
    is_call |-> ##2 o_squashed || (o_stack_top == $past(o_pc, 2) + 15'h0001 && o_stack_ptr == $past(o_stack_ptr, 2) + 4'h1);
  endproperty
  property p_call_len;
    is_call |=> !o_ready ##1 ((o_ready && o_squashed) or (!o_ready ##1 o_ready));
  endproperty
  property p_keep_z;
    is_call || is_dsk |-> ##2 o_zero_flag == $past(o_zero_flag, 2);
  endproperty
  property p_clear_accum_op;
    is_clear_accum_op |-> ##2 o_squashed || (o_zero_flag && o_accum == 8'h00);
  endproperty
  property p_clear_file_op;
    is_clear_file_op |-> ##2 o_squashed || o_zero_flag;
  endproperty
  property p_single;
    take && i_opcode != `OP_ACCUM_CALL |=> !o_ready ##1 o_ready;
  endproperty
  property p_squash;
    o_squashed |-> o_pc == $past(o_pc, 2) + 15'h0001 && o_accum == $past(o_accum, 2);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear effects missing");
  a_call_pc: assert property (p_call_pc) else $error("call target wrong");
  a_push: assert property (p_push) else $error("return address push wrong");
  a_call_len: assert property (p_call_len) else $error("call length wrong");
  a_keep_z: assert property (p_keep_z) else $error("zero flag disturbed");
  a_clear_accum_op: assert property (p_clear_accum_op) else $error("accumulator clear wrong");
  a_clear_file_op: assert property (p_clear_file_op) else $error("file clear zero flag wrong");
  a_single: assert property (p_single) else $error("single cycle timing wrong");
  a_squash: assert property (p_squash) else $error("squashed slot had effects");
  c_call: cover property (is_call);
  c_squash: cover property (o_squashed);
  c_wdt: cover property (o_wdt_clear);
endmodule : cpu_exec_properties

bind cpu_instr_exec_subset cpu_exec_properties u_cpu_exec_properties (.i_clock, .i_srst, .i_instr_valid,
  .i_opcode, .i_pc_high_latch, .o_ready, .o_pc, .o_accum, .o_zero_flag, .o_timeout_flag_n,
  .o_powerdown_flag_n, .o_wdt_clear, .o_prescaler_clear, .o_stack_top, .o_stack_ptr, .o_squashed);
`default_nettype wire

//--- tb/cpu_instr_exec_subset_tb_top.sv
// Self-checking bench for the execution subset
`timescale 1ns/1ns
`default_nettype none
`include "cpu_exec_defines.svh"
module cpu_instr_exec_subset_tb_top;
  import cpu_exec_pkg::*;
  typedef struct packed {
    pc_t pc; byte_t acc; logic z; logic to_n; logic pd_n; logic wdt; logic sq; logic un; pc_t stack_top; logic [3:0] sp;
  } note_t;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic i_instr_valid = 1'b0;
  logic i_timeout_event = 1'b0;
  logic i_sleep_entry = 1'b0;
  opcode_t i_opcode = 14'h0000;
  logic [1:0] i_bank = 2'h0;
  logic [6:0] i_pc_high_latch = 7'h00;
  logic o_ready, o_zero_flag, o_timeout_flag_n, o_powerdown_flag_n, o_wdt_clear, o_prescaler_clear;
  logic o_squashed, o_unhandled;
  pc_t o_pc, o_stack_top;
  byte_t o_accum;
  logic [3:0] o_stack_ptr;
  note_t m;
  note_t q[$];
  byte_t mem [512];
  logic skip = 1'b0;
  logic rdy_q = 1'b1;
  logic [1:0] bk;
  opcode_t f;
  int num_errors = 0;
  int n_tests = 0;

  cpu_instr_exec_subset u_cpu_instr_exec_subset (.i_clock, .i_srst, .i_instr_valid, .i_opcode, .i_bank,
    .i_pc_high_latch, .i_timeout_event, .i_sleep_entry, .o_ready, .o_pc, .o_accum, .o_zero_flag,
    .o_timeout_flag_n, .o_powerdown_flag_n, .o_wdt_clear, .o_prescaler_clear, .o_stack_top,
    .o_stack_ptr, .o_squashed, .o_unhandled);

  initial forever #25 i_clock = ~i_clock;

  // ----
  // Compare, drive and report tasks
  // ----
  task automatic check_state(input note_t e);
    note_t a;
    // Counter and prescaler clears must pulse together; a split shows as unknown
    a = {o_pc, o_accum, o_zero_flag, o_timeout_flag_n, o_powerdown_flag_n,
         ((o_wdt_clear === o_prescaler_clear) ? o_wdt_clear : 1'bx),
         o_squashed, o_unhandled, o_stack_top, o_stack_ptr};
    n_tests++;
    if (a !== e) begin
      num_errors++;
      $display("Error %0t: state %h expected %h", $time, a, e);
    end
  endtask : check_state

  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Notes the expected state, then offers the opcode until taken
  task automatic exec(input opcode_t op);
    logic [8:0] fa;
    byte_t r;
    int k;
    fa = {bk, op[6:0]};
    r = mem[fa];
    m.wdt = 1'b0;
    m.sq = 1'b0;
    m.un = 1'b0;
    m.pc = m.pc + 15'h0001;
    if (skip) begin
      m.sq = 1'b1;
      skip = 1'b0;
    end else if (op == `OP_WDT_CLEAR) begin
      m.to_n = 1'b1;
      m.pd_n = 1'b1;
      m.wdt = 1'b1;
    end else if (op == `OP_ACCUM_CALL) begin
      m.stack_top = m.pc;
      m.sp = m.sp + 4'h1;
      m.pc = {i_pc_high_latch, m.acc};
    end else if ((op & `OP_MASK_F) == `OP_CLEAR_ACCUM) begin
      m.acc = 8'h00;
      m.z = 1'b1;
    end else if ((op & `OP_MASK_F) == `OP_CLEAR_FILE) begin
      mem[fa] = 8'h00;
      m.z = 1'b1;
    end else begin
      case (op & `OP_MASK_FD)
        `OP_COMPLEMENT: r = ~r;
        `OP_DECREMENT, `OP_DEC_SKIP: r = r - 8'h01;
        default: m.un = 1'b1;
      endcase
      if (!m.un && op[7]) mem[fa] = r;
      if (!m.un && !op[7]) m.acc = r;
      if ((op & `OP_MASK_FD) == `OP_DEC_SKIP) skip = (r == 8'h00);
      else if (!m.un) m.z = (r == 8'h00);
    end
    q.push_back(m);
    i_opcode <= op;
    i_bank <= bk;
    i_instr_valid <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clock);
      if (o_ready === 1'b1) break;
    end
    if (k == 20) begin
      num_errors++;
      print_verdict();
    end
  endtask : exec

  // Pulses both status events between instructions
  task automatic idle_events();
    @(posedge i_clock);
    i_instr_valid <= 1'b0;
    i_timeout_event <= 1'b1;
    i_sleep_entry <= 1'b1;
    @(posedge i_clock);
    i_timeout_event <= 1'b0;
    i_sleep_entry <= 1'b0;
    m.to_n = 1'b0;
    m.pd_n = 1'b0;
  endtask : idle_events

  // Result watcher: oldest note against settled outputs
  always @(negedge i_clock) begin
    if (o_ready === 1'b1 && rdy_q === 1'b0 && q.size() > 0) check_state(q.pop_front());
    rdy_q = o_ready;
  end

  initial begin
    void'($urandom(32'h0d05));
    repeat (3) @(posedge i_clock);
    i_srst <= 1'b0;
    m = '0;
    m.to_n = 1'b1;
    m.pd_n = 1'b1;
    @(negedge i_clock);
    check_state(m);
    @(posedge i_clock);
    for (int t = 0; t < 3; t++) begin
      bk = 2'($urandom);
      f = 14'($urandom) & 14'h007F;
      i_pc_high_latch <= 7'($urandom);
      exec(`OP_CLEAR_FILE | f); // File to zero
      exec(`OP_DECREMENT | 14'h0080 | f); // Wrap to all ones
      exec(`OP_COMPLEMENT | f); // To accumulator
      exec(`OP_DECREMENT | f); // To accumulator
      exec(`OP_ACCUM_CALL); // Computed call
      exec(`OP_DECREMENT | 14'h0080 | f); // File down again
      exec(`OP_COMPLEMENT | 14'h0080 | f); // Back to file
      exec(`OP_DEC_SKIP | f); // Zero result, flag kept
      exec(`OP_CLEAR_ACCUM); // Squashed slot
      exec(`OP_DEC_SKIP | 14'h0080 | f); // Zero in file
      exec(`OP_ACCUM_CALL); // Squashed call, no push
      exec(`OP_CLEAR_ACCUM); // Accumulator clear
      exec(`OP_DEC_SKIP | 14'h0080 | f); // Nonzero, no skip
      exec(`OP_COMPLEMENT | f); // Reads back file
      exec(14'h3FFF); // Outside the group
      idle_events();
      exec(`OP_CLEAR_ACCUM); // Flags low now
      exec(`OP_WDT_CLEAR); // Flags set, pulses
    end
    @(posedge i_clock);
    i_instr_valid <= 1'b0;
    for (int k = 0; k < 40 && q.size() > 0; k++) @(negedge i_clock);
    if (q.size() > 0) num_errors++;
    print_verdict();
  end
endmodule : cpu_instr_exec_subset_tb_top
`default_nettype wire
